// [acp_pkg.sv]
package acp_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CONFIG         = 8'h00;
	localparam logic [7:0] ADDR_CHIP_ID        = 8'h01;
	localparam logic [7:0] ADDR_GRADE          = 8'h02;
	localparam logic [7:0] ADDR_DEV_INDEX      = 8'h05;
	localparam logic [7:0] ADDR_FUNC_FIRST     = 8'h08;
	localparam logic [7:0] ADDR_CLOCK_CONTROL  = 8'h09;
	localparam logic [7:0] ADDR_FUNC_LAST      = 8'h22;
	localparam logic [7:0] ADDR_UPDATE_TRIGGER = 8'hff;
	localparam int         FUNC_COUNT          = 27;
	// ==========================================================
	// Reset values and fields
	localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h01;
	localparam logic [7:0] FUNC_RESET          = 8'h00;
	localparam logic [5:0] DEV_INDEX_RESET     = 6'h0f;
	localparam logic [7:0] CONFIG_FIXED        = 8'h18;
	localparam int         CLOCK_DCS_BIT       = 0;
	localparam int         CFG_LSB_HI          = 6;
	localparam int         CFG_LSB_LO          = 1;
	localparam int         CFG_SRST_HI         = 5;
	localparam int         CFG_SRST_LO         = 2;
	localparam int         UPDATE_BIT          = 0;
	// ==========================================================
	// Framing and counts
	localparam logic [1:0] COUNT_STREAM        = 2'h3;
	localparam logic [3:0] INSTR_LAST_BIT      = 4'hf;
	localparam logic [3:0] DATA_LAST_BIT       = 4'h7;
	localparam logic [1:0] STRAP_WAIT          = 2'h3;
	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ST_OFF   = 2'b00,
		ST_INSTR = 2'b01,
		ST_DATA  = 2'b10,
		ST_DONE  = 2'b11
	} acp_state_t;
	typedef struct packed {
		logic        read;
		logic [1:0]  count;
		logic [12:0] addr;
	} acp_instr_t;
	typedef struct packed {
		logic csb_up;
		logic sclk_down;
		logic sdio_down;
	} acp_term_t;
	localparam acp_term_t TERM_ON = 3'h7;
endpackage

// [acp_serial_config_port.sv]
`timescale 1ns/10ps
// Overview of operation
// - Clock and select are inputs; data pin driven only during readback.
// - Select high at power-up disables the port and exposes strap functions.
// - Each port pin has a termination pulling it to its inactive level.
// - Map: config 0x00-0x02, index 0x05, trigger 0xff, functions 0x08-0x22.
// - Function writes take effect only after writing one to the trigger.
// - Clock register resets to one; bit 0 enables the duty cycle stabilizer.
// - Reset loads default values; undefined bits have no function.
// - Frame is a 16-bit instruction then one or more data bytes.
// - Byte count three streams bytes until select rises.
// - Select rising mid-byte resets the engine to await an instruction.
// - Bits shift MSB first until configuration selects LSB first.
module acp_serial_config_port #(
	parameter logic [7:0] CHIP_ID  = 8'h5a, // Arbitrary value
	parameter logic [2:0] GRADE_ID = 3'h0   // Arbitrary value
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  sclk,
	input  wire logic                  chip_select_n,
	input  wire logic                  sdio_in,
	output logic                       sdio_out,
	output logic                       sdio_oe,
	output logic                       port_disabled,
	output logic                       test_pattern_strap,
	output logic                       output_mode_strap,
	output acp_pkg::acp_term_t         pin_term,
	output logic                       lsb_first,
	output logic                       dcs_enable,
	output logic [5:0]                 dev_index,
	output logic [26:0][7:0]           func_active
);
	// ==========================================================
	// Pin synchronisers
	logic [2:0]               s_sclk;
	logic [2:0]               s_csb;
	logic [1:0]               s_sdio;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_sclk <= 3'h0;
			s_csb  <= 3'h7;
			s_sdio <= 2'h0;
		end else begin
			s_sclk <= {s_sclk[1:0], sclk};
			s_csb  <= {s_csb[1:0], chip_select_n};
			s_sdio <= {s_sdio[0], sdio_in};
		end
	end

	// ==========================================================
	// Helpers
	function automatic logic is_func(input logic [12:0] a);
		return a[12:8] == 5'h00 && a[7:0] >= acp_pkg::ADDR_FUNC_FIRST &&
			a[7:0] <= acp_pkg::ADDR_FUNC_LAST;
	endfunction

	function automatic logic [4:0] func_idx(input logic [12:0] a);
		return 5'(a[7:0] - acp_pkg::ADDR_FUNC_FIRST);
	endfunction

	function automatic logic [7:0] func_default(input int i);
		return (i == 1) ? acp_pkg::CLOCK_CONTROL_RESET : acp_pkg::FUNC_RESET;
	endfunction

	// ==========================================================
	// Serial engine and registers
	acp_pkg::acp_state_t      state, next_state;
	logic [3:0]               bit_cnt, next_bit_cnt;
	logic [15:0]              rx, next_rx;
	acp_pkg::acp_instr_t      instr, next_instr;
	logic [1:0]               bytes_left, next_bytes_left;
	logic [7:0]               tx, next_tx;
	logic [26:0][7:0]         staged, next_staged;
	logic [26:0][7:0]         next_func_active;
	logic                     xfer_pend, next_xfer_pend;
	logic [1:0]               strap_cnt, next_strap_cnt;
	logic                     next_sdio_out, next_sdio_oe, next_port_disabled;
	logic                     next_tp_strap, next_om_strap, next_lsb_first;
	logic                     next_dcs_enable;
	logic [5:0]               next_dev_index;
	logic                     sclk_rise, sclk_fall, csb_hi, din, stream;
	logic [15:0]              rx_new, rx_rev;
	logic [7:0]               wdata;
	acp_pkg::acp_instr_t      ins;
	logic [12:0]              nxt_addr;

	function automatic logic [7:0] read_byte(input logic [12:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a[12:8] == 5'h00) begin
			case (a[7:0])
				acp_pkg::ADDR_CONFIG: begin
					v = acp_pkg::CONFIG_FIXED;
					v[acp_pkg::CFG_LSB_HI] = lsb_first;
					v[acp_pkg::CFG_LSB_LO] = lsb_first;
				end
				acp_pkg::ADDR_CHIP_ID:   v = CHIP_ID;
				acp_pkg::ADDR_GRADE:     v = {1'b0, GRADE_ID, 4'h0};
				acp_pkg::ADDR_DEV_INDEX: v = {2'b00, dev_index};
				default: begin
					if (is_func(a)) begin
						v = staged[func_idx(a)];
					end
				end
			endcase
		end
		return v;
	endfunction

	always_comb begin
		next_state         = state;
		next_bit_cnt       = bit_cnt;
		next_rx            = rx;
		next_instr         = instr;
		next_bytes_left    = bytes_left;
		next_tx            = tx;
		next_staged        = staged;
		next_func_active   = func_active;
		next_xfer_pend     = 1'b0;
		next_strap_cnt     = strap_cnt;
		next_sdio_out      = sdio_out;
		next_sdio_oe       = sdio_oe;
		next_port_disabled = port_disabled;
		next_tp_strap      = 1'b0;
		next_om_strap      = 1'b0;
		next_lsb_first     = lsb_first;
		next_dev_index     = dev_index;
		sclk_rise = s_sclk[1] & ~s_sclk[2];
		sclk_fall = ~s_sclk[1] & s_sclk[2];
		csb_hi    = s_csb[1];
		din       = s_sdio[1];
		stream    = instr.count == acp_pkg::COUNT_STREAM;
		rx_new    = {rx[14:0], din};
		rx_rev    = {<<{rx_new}};
		wdata     = lsb_first ? rx_rev[15:8] : rx_new[7:0];
		ins       = lsb_first ? rx_rev : rx_new;
		nxt_addr  = lsb_first ? instr.addr + 13'h1 : instr.addr - 13'h1;
		if (xfer_pend) begin
			next_func_active = staged;
		end
		next_dcs_enable = func_active[1][acp_pkg::CLOCK_DCS_BIT];
		case (state)
			acp_pkg::ST_OFF: begin
				if (strap_cnt != acp_pkg::STRAP_WAIT) begin
					next_strap_cnt = strap_cnt + 2'h1;
				end else if (csb_hi || port_disabled) begin
					next_port_disabled = 1'b1;
					next_tp_strap      = s_sclk[1];
					next_om_strap      = din;
				end else begin
					next_state = acp_pkg::ST_INSTR;
				end
			end
			default: begin
				if (csb_hi) begin
					next_sdio_oe = 1'b0;
					if (bit_cnt[2:0] != 3'h0 || state == acp_pkg::ST_DONE ||
						(state == acp_pkg::ST_DATA && stream)) begin
						next_state   = acp_pkg::ST_INSTR;
						next_bit_cnt = 4'h0;
					end
				end else begin
					if (sclk_rise && state != acp_pkg::ST_DONE) begin
						next_rx      = rx_new;
						next_bit_cnt = bit_cnt + 4'h1;
						if (state == acp_pkg::ST_INSTR && bit_cnt == acp_pkg::INSTR_LAST_BIT) begin
							next_instr      = ins;
							next_state      = acp_pkg::ST_DATA;
							next_bit_cnt    = 4'h0;
							next_bytes_left = ins.count;
							next_tx         = read_byte(ins.addr);
						end
						if (state == acp_pkg::ST_DATA && bit_cnt == acp_pkg::DATA_LAST_BIT) begin
							next_bit_cnt = 4'h0;
							if (!instr.read && instr.addr[12:8] == 5'h00) begin
								if (instr.addr[7:0] == acp_pkg::ADDR_CONFIG) begin
									next_lsb_first = wdata[acp_pkg::CFG_LSB_HI] |
										wdata[acp_pkg::CFG_LSB_LO];
									if (wdata[acp_pkg::CFG_SRST_HI] | wdata[acp_pkg::CFG_SRST_LO]) begin
										next_lsb_first = 1'b0;
										next_dev_index = acp_pkg::DEV_INDEX_RESET;
										for (int i = 0; i < acp_pkg::FUNC_COUNT; i++) begin
											next_staged[i]      = func_default(i);
											next_func_active[i] = func_default(i);
										end
									end
								end else if (instr.addr[7:0] == acp_pkg::ADDR_DEV_INDEX) begin
									next_dev_index = wdata[5:0];
								end else if (is_func(instr.addr)) begin
									next_staged[func_idx(instr.addr)] = wdata;
								end else if (instr.addr[7:0] == acp_pkg::ADDR_UPDATE_TRIGGER) begin
									next_xfer_pend = wdata[acp_pkg::UPDATE_BIT];
								end
							end
							next_instr.addr = nxt_addr;
							next_tx         = read_byte(nxt_addr);
							if (!stream) begin
								if (bytes_left == 2'h0) begin
									next_state = acp_pkg::ST_DONE;
								end else begin
									next_bytes_left = bytes_left - 2'h1;
								end
							end
						end
					end
					if (sclk_fall) begin
						next_sdio_oe  = state == acp_pkg::ST_DATA && instr.read;
						next_sdio_out = lsb_first ? tx[bit_cnt[2:0]] : tx[3'h7 - bit_cnt[2:0]];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state              <= acp_pkg::ST_OFF;
			bit_cnt            <= 4'h0;
			rx                 <= 16'h0000;
			instr              <= '0;
			bytes_left         <= 2'h0;
			tx                 <= 8'h00;
			xfer_pend          <= 1'b0;
			strap_cnt          <= 2'h0;
			sdio_out           <= 1'b0;
			sdio_oe            <= 1'b0;
			port_disabled      <= 1'b0;
			test_pattern_strap <= 1'b0;
			output_mode_strap  <= 1'b0;
			lsb_first          <= 1'b0;
			dcs_enable         <= 1'b1;
			dev_index          <= acp_pkg::DEV_INDEX_RESET;
			pin_term           <= acp_pkg::TERM_ON;
			for (int i = 0; i < acp_pkg::FUNC_COUNT; i++) begin
				staged[i]      <= func_default(i);
				func_active[i] <= func_default(i);
			end
		end else begin
			state              <= next_state;
			bit_cnt            <= next_bit_cnt;
			rx                 <= next_rx;
			instr              <= next_instr;
			bytes_left         <= next_bytes_left;
			tx                 <= next_tx;
			xfer_pend          <= next_xfer_pend;
			strap_cnt          <= next_strap_cnt;
			sdio_out           <= next_sdio_out;
			sdio_oe            <= next_sdio_oe;
			port_disabled      <= next_port_disabled;
			test_pattern_strap <= next_tp_strap;
			output_mode_strap  <= next_om_strap;
			lsb_first          <= next_lsb_first;
			dcs_enable         <= next_dcs_enable;
			dev_index          <= next_dev_index;
			pin_term           <= acp_pkg::TERM_ON;
			staged             <= next_staged;
			func_active        <= next_func_active;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_oe_read_only: assert property (sdio_oe |-> instr.read && !s_csb[2])
		else $error("Data pin driven outside a readback");
	a_strap_no_drive: assert property (port_disabled |-> !sdio_oe && state == acp_pkg::ST_OFF)
		else $error("Disabled port left active");
	a_term_held: assert property (pin_term == acp_pkg::TERM_ON)
		else $error("Pin termination lost");
	a_update_gated: assert property (!xfer_pend && state != acp_pkg::ST_DATA ##1 !xfer_pend
		|=> $stable(func_active))
		else $error("Active registers changed without trigger");
	a_reset_clock: assert property ($past(rst) |-> func_active[1] == acp_pkg::CLOCK_CONTROL_RESET
		&& staged[1] == acp_pkg::CLOCK_CONTROL_RESET)
		else $error("Clock register not at default after reset");
	a_stream_hold: assert property (state == acp_pkg::ST_DATA && stream && !csb_hi
		|=> state == acp_pkg::ST_DATA)
		else $error("Streaming ended without select rising");
	a_mid_byte_abort: assert property (csb_hi && state != acp_pkg::ST_OFF && bit_cnt[2:0] != 3'h0
		|=> state == acp_pkg::ST_INSTR && bit_cnt == 4'h0 ##1 !sdio_oe)
		else $error("Engine not reset by select mid-byte");
	a_transfer_clear: assert property (xfer_pend |=> !xfer_pend && func_active == $past(staged))
		else $error("Trigger did not copy and clear");
endmodule

// [acp_spi_master.sv]
`timescale 1ns/10ps
// ==========================================================
// Serial master model for the configuration port
module acp_spi_master (
	input  wire logic clk,
	input  wire logic sdio_wire,
	output logic      sclk,
	output logic      chip_select_n,
	output logic      m_oe,
	output logic      m_out
);
	initial begin
		sclk = 1'b0;
		chip_select_n = 1'b0;
		m_oe = 1'b0;
		m_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Serial clock stands low outside frames
	task automatic start();
		chip_select_n = 1'b0;
		tick(4);
	endtask
	task automatic stop();
		m_oe = 1'b0;
		tick(4);
		chip_select_n = 1'b1;
		tick(8);
	endtask
	// Data changes while clock is low, read sampled before the rise
	task automatic bits(
		input  int          n,
		input  logic [15:0] v,
		input  logic        drive,
		input  logic        lsb,
		output logic [15:0] r
	);
		int k;
		r = 16'h0000;
		for (int i = 0; i < n; i++) begin
			k = lsb ? i : n - 1 - i;
			m_oe = drive;
			m_out = v[k];
			tick(4);
			r[k] = sdio_wire;
			sclk = 1'b1;
			tick(4);
			sclk = 1'b0;
		end
	endtask
endmodule

// [test_adc_serial_config_port.sv]
`timescale 1ns/10ps
module test_adc_serial_config_port;
	logic               clk;
	logic               rst;
	logic               sclk;
	logic               chip_select_n;
	logic               m_oe;
	logic               m_out;
	logic               sdio_wire;
	logic               sdio_out;
	logic               sdio_oe;
	logic               port_disabled;
	logic               test_pattern_strap;
	logic               output_mode_strap;
	acp_pkg::acp_term_t pin_term;
	logic               lsb_first;
	logic               dcs_enable;
	logic [5:0]         dev_index;
	logic [26:0][7:0]   func_active;
	int                 failures;
	int                 checks_done;
	int                 cycles;
	int                 clash;
	logic [15:0]        r;
	// Pull-down termination holds a released data line low
	assign sdio_wire = sdio_oe ? sdio_out : (m_oe ? m_out : 1'b0);
	acp_spi_master u_acp_spi_master (.clk(clk), .sdio_wire(sdio_wire), .sclk(sclk),
		.chip_select_n(chip_select_n), .m_oe(m_oe), .m_out(m_out));
	acp_serial_config_port u_acp_serial_config_port (.clk(clk), .rst(rst), .sclk(sclk),
		.chip_select_n(chip_select_n), .sdio_in(sdio_wire), .sdio_out(sdio_out),
		.sdio_oe(sdio_oe), .port_disabled(port_disabled),
		.test_pattern_strap(test_pattern_strap), .output_mode_strap(output_mode_strap),
		.pin_term(pin_term), .lsb_first(lsb_first), .dcs_enable(dcs_enable),
		.dev_index(dev_index), .func_active(func_active));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (m_oe && sdio_oe) clash++;
		if (cycles == 20000) begin
			failures++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		u_acp_spi_master.start();
		u_acp_spi_master.bits(16, {3'b000, a}, 1'b1, 1'b0, r);
		u_acp_spi_master.bits(8, {8'h00, d}, 1'b1, 1'b0, r);
		u_acp_spi_master.stop();
	endtask
	task automatic rd(input logic [12:0] a, input logic [7:0] e, input logic lsb);
		u_acp_spi_master.start();
		u_acp_spi_master.bits(16, {3'b100, a}, 1'b1, lsb, r);
		u_acp_spi_master.bits(8, 16'h0000, 1'b0, lsb, r);
		u_acp_spi_master.stop();
		chk(r[7:0], e);
	endtask
	task automatic t_defaults();
		chk(func_active[1], 8'h01);
		chk({7'h00, dcs_enable}, 8'h01);
		chk({2'h0, dev_index}, 8'h0f);
		chk({5'h00, pin_term}, 8'h07);
		chk({6'h00, port_disabled, sdio_oe}, 8'h00);
	endtask
	task automatic t_staged();
		wr(13'h0009, 8'h00);
		chk({7'h00, dcs_enable}, 8'h01);
		rd(13'h0009, 8'h00, 1'b0);
		wr(13'h00ff, 8'h01);
		chk({7'h00, dcs_enable}, 8'h00);
		rd(13'h00ff, 8'h00, 1'b0);
	endtask
	task automatic t_map();
		wr(13'h0003, 8'h55);
		rd(13'h0003, 8'h00, 1'b0);
		rd(13'h0000, 8'h18, 1'b0);
		rd(13'h0005, 8'h0f, 1'b0);
		rd(13'h0022, 8'h00, 1'b0);
		chk({7'h00, sdio_oe}, 8'h00);
		chk(clash[7:0], 8'h00);
	endtask
	task automatic t_stream();
		u_acp_spi_master.start();
		u_acp_spi_master.bits(16, 16'h600a, 1'b1, 1'b0, r);
		u_acp_spi_master.bits(8, 16'h0012, 1'b1, 1'b0, r);
		u_acp_spi_master.bits(8, 16'h0034, 1'b1, 1'b0, r);
		u_acp_spi_master.stop();
		chk(func_active[2], 8'h00);
		wr(13'h00ff, 8'h01);
		chk(func_active[2], 8'h12);
		chk(func_active[1], 8'h34);
	endtask
	task automatic t_abort();
		u_acp_spi_master.start();
		u_acp_spi_master.bits(16, 16'h0008, 1'b1, 1'b0, r);
		u_acp_spi_master.bits(4, 16'h000f, 1'b1, 1'b0, r);
		u_acp_spi_master.stop();
		wr(13'h000b, 8'h77);
		wr(13'h00ff, 8'h01);
		chk(func_active[3], 8'h77);
		chk(func_active[0], 8'h00);
	endtask
	task automatic t_order();
		wr(13'h0000, 8'h42);
		chk({7'h00, lsb_first}, 8'h01);
		rd(13'h0005, 8'h0f, 1'b1);
		u_acp_spi_master.start();
		u_acp_spi_master.bits(16, 16'h0000, 1'b1, 1'b1, r);
		u_acp_spi_master.bits(8, 16'h0000, 1'b1, 1'b1, r);
		u_acp_spi_master.stop();
		chk({7'h00, lsb_first}, 8'h00);
		// Soft reset reloads every default at once
		wr(13'h0000, 8'h24);
		chk(func_active[1], 8'h01);
		chk(func_active[3], 8'h00);
		chk({7'h00, dcs_enable}, 8'h01);
		rd(13'h0000, 8'h18, 1'b0);
	endtask
	task automatic t_strap();
		rst = 1'b1;
		u_acp_spi_master.tick(2);
		rst = 1'b0;
		u_acp_spi_master.tick(8);
		chk({7'h00, port_disabled}, 8'h01);
		u_acp_spi_master.sclk = 1'b1;
		u_acp_spi_master.tick(6);
		chk({7'h00, test_pattern_strap}, 8'h01);
		u_acp_spi_master.sclk = 1'b0;
		u_acp_spi_master.m_out = 1'b1;
		u_acp_spi_master.m_oe = 1'b1;
		u_acp_spi_master.tick(6);
		chk({7'h00, test_pattern_strap}, 8'h00);
		chk({7'h00, output_mode_strap}, 8'h01);
		u_acp_spi_master.m_oe = 1'b0;
		u_acp_spi_master.tick(6);
		chk({7'h00, output_mode_strap}, 8'h00);
	endtask
	task automatic complete_run();
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		u_acp_spi_master.tick(8);
		u_acp_spi_master.chip_select_n = 1'b1;
		u_acp_spi_master.tick(8);
		t_defaults();
		t_staged();
		t_map();
		t_stream();
		t_abort();
		t_order();
		t_strap();
		complete_run();
	end
endmodule
